/* hdl/sar_adc_sequencer.sv */
// sequencer, register file and compare monitors of the 8-channel converter
// Summary of operation
// RULE1: single mode converts selected channel once
// RULE2: start bit reads one while busy, auto-clears
// RULE3: single mode uses lowest enabled channel only
// RULE4: single scan converts enabled channels ascending once
// RULE5: end flag after single conversion or pass
// RULE6: start cleared mid-scan: finish current, store, stop
// RULE7: continuous scan repeats passes while start set
// RULE8: software clears start before changing mode/channel
// RULE9: converter clock: four sources, divide by N+1
// RULE10: trigger source 00b takes the external pin
// RULE11: pin condition falling, rising, low, high
// RULE12: level held eight clocks, start on ninth
// RULE13: level trigger keeps converting while active
// RULE14: edge needs both phases four clocks long
// RULE15: trigger source 11b takes PWM trigger events
// RULE16: compare unit picks channel, direction, value
// RULE17: match counter counts matches, clears on mismatch
// RULE18: counter reaching setting plus one sets flag
// RULE19: interrupt from any flag with its enable
// RULE20: clearing a flag withdraws its request
// RULE21: channel 7 selects pin or band-gap
// RULE22: valid set on conversion, cleared on read
// RULE23: overwrite of unread result sets overrun
// RULE24: result unsigned or sign-extended two's complement
// RULE25: reset leaves block idle, flags cleared
// RULE26: interrupt is a level while flags pend
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/100ps
`include "adc_seq_defs.svh"
module sar_adc_sequencer
    import adc_seq_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic [31:0]      rdata,
    input  wire logic        external_trigger_pin,
    input  wire logic        pwm_trig,
    input  wire logic [3:0]  clk_src_tick,
    input  wire logic        conv_done,
    input  wire logic [11:0] conv_data,
    output logic             conv_tick,
    output logic             conv_start,
    output logic [2:0]       conv_chan,
    output logic             ch7_bandgap_sel,
    output logic             irq
);
    seq_state_type state_r;
    logic [2:0]    chan_r;
    logic          conv_start_r, tick_r, irq_r, bg_r;
    logic          en_r, ie_r, ext_trigger_enable_r, format_r, start_r, start_nxt;
    logic [1:0]    mode_r, trigger_source_select_r, cond_r, clksel_r;
    logic [7:0]    channel_enable_bits_r, div_r, pre_cnt_r, valid_r, ovr_r;
    logic [31:0]   cmp_r [2];
    logic [4:0]    match_cnt_r [2];
    logic          end_flag_r;
    logic [1:0]    cmp_flag_r, cmp_set;
    logic [3:0]    first_lo, next_up;
    logic          res_we, pass_done, hw_clear, trig_set;
    logic          edge_go, level_ok, res_sel, rd_res;
    logic [2:0]    res_idx;
    logic [7:0]    res_hit, rd_clr;
    logic [15:0]   res_word;
    logic [31:0]   alt_word;

    // lowest enabled channel at or above a start index, bit 3 = found
    function automatic logic [3:0] first_from(input logic [7:0] en,
                                              input logic [3:0] from);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 7; i >= 0; i--)
            if (en[i] && 4'(i) >= from)
                r = {1'b1, 3'(i)};
        return r;
    endfunction

    assign first_lo = first_from(channel_enable_bits_r, 4'h0);
    assign next_up  = first_from(channel_enable_bits_r, {1'b0, chan_r} + 4'h1);
    assign res_we   = (state_r == st_wait) && conv_done;
    assign pass_done = res_we && (mode_r == `MODE_SINGLE || !next_up[3]);
    assign res_sel  = (addr <= `OFS_RESULT_TOP) && (addr[1:0] == 2'h0);
    assign res_idx  = addr[4:2];
    assign rd_res   = rd && res_sel;
    assign rd_clr   = rd_res ? (8'h01 << res_idx) : 8'h00;
    assign res_hit  = res_we ? (8'h01 << chan_r) : 8'h00;

    always_comb
    begin
        if (format_r)
            res_word = {{4{~conv_data[11]}}, ~conv_data[11],
                        conv_data[10:0]};                      // [RULE24]
        else
            res_word = {4'h0, conv_data};                      // [RULE24]
    end

    ext_trigger_filter u_trig
    (
        .clk      (clk),
        .rst      (rst),
        .ce       (ce),
        .pin      (external_trigger_pin),
        .cond     (cond_r),                                    // [RULE11]
        .edge_go  (edge_go),
        .level_ok (level_ok)
    );

    // external starts only apply to single-cycle scan mode
    always_comb
    begin
        trig_set = 1'b0;
        if (ext_trigger_enable_r && mode_r == `MODE_SCAN)
        begin
            if (trigger_source_select_r == `TRG_PIN)                            // [RULE10]
                trig_set = edge_go || (level_ok && !start_r &&
                           state_r == st_idle);                // [RULE13]
            else if (trigger_source_select_r == `TRG_PWM)
                trig_set = pwm_trig;                           // [RULE15]
        end
    end

    assign hw_clear = (pass_done && mode_r != `MODE_CONT) ||
                      (state_r == st_idle && start_r &&
                       !(en_r && first_lo[3]));

    always_comb
    begin
        start_nxt = start_r;
        if (hw_clear)
            start_nxt = 1'b0;                                  // [RULE2]
        if (wr && addr == `OFS_CTRL)
            start_nxt = wdata[`B_START];
        if (trig_set)
            start_nxt = 1'b1;
    end

    // mode and channel are sampled live; software stops the run first
    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            en_r     <= 1'b0;
            ie_r     <= 1'b0;
            mode_r   <= `MODE_SINGLE;
            trigger_source_select_r   <= `TRG_PIN;
            cond_r   <= `COND_FALL;
            ext_trigger_enable_r  <= 1'b0;
            format_r <= 1'b0;
            start_r  <= 1'b0;
            channel_enable_bits_r   <= 8'h00;
            clksel_r <= 2'h0;
            div_r    <= 8'h00;
            bg_r     <= 1'b0;
        end
        else if (ce)
        begin
            start_r <= start_nxt;
            if (wr && addr == `OFS_CTRL)                       // [RULE8]
            begin
                en_r     <= wdata[`B_EN];
                ie_r     <= wdata[`B_IE];
                mode_r   <= wdata[`B_MODE];
                trigger_source_select_r   <= wdata[`B_TRIGGER_SOURCE_SELECT];
                cond_r   <= wdata[`B_TRIGGER_CONDITION_SELECT];
                ext_trigger_enable_r  <= wdata[`B_EXT_TRIGGER_ENABLE];
                format_r <= wdata[`B_FORMAT];
            end
            else if (wr && addr == `OFS_CHANNEL_ENABLE_BITS)
                channel_enable_bits_r <= wdata[`B_CHANNEL_ENABLE_BITS];
            else if (wr && addr == `OFS_CLKCFG)
            begin
                clksel_r <= wdata[`B_CK_SEL];
                div_r    <= wdata[`B_CK_DIV];
                bg_r     <= wdata[`B_CK_BG];                   // [RULE21]
            end
        end

    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            state_r      <= st_idle;                           // [RULE25]
            chan_r       <= 3'h0;
            conv_start_r <= 1'b0;
        end
        else if (ce)
        begin
            conv_start_r <= 1'b0;
            case (state_r)
                st_idle:
                    if (start_r && en_r && first_lo[3])
                    begin
                        chan_r  <= first_lo[2:0];              // [RULE3]
                        state_r <= st_launch;
                    end
                st_launch:
                begin
                    conv_start_r <= 1'b1;
                    state_r      <= st_wait;
                end
                st_wait:
                    if (conv_done)
                    begin
                        if (mode_r != `MODE_SINGLE && start_r &&
                            next_up[3])
                        begin
                            chan_r  <= next_up[2:0];           // [RULE4]
                            state_r <= st_launch;
                        end
                        else if (mode_r == `MODE_CONT && start_r &&
                                 first_lo[3])
                        begin
                            chan_r  <= first_lo[2:0];          // [RULE7]
                            state_r <= st_launch;
                        end
                        else
                            state_r <= st_idle;       // [RULE1] [RULE6]
                    end
                default:
                    state_r <= st_idle;
            endcase
        end

    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            pre_cnt_r <= 8'h00;
            tick_r    <= 1'b0;
        end
        else if (ce)
        begin
            tick_r <= 1'b0;
            if (clk_src_tick[clksel_r])
            begin
                if (pre_cnt_r >= div_r)
                begin
                    pre_cnt_r <= 8'h00;
                    tick_r    <= 1'b1;                         // [RULE9]
                end
                else
                    pre_cnt_r <= pre_cnt_r + 8'h01;
            end
        end

    // a new result wins over a read clear in the same cycle
    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            valid_r <= 8'h00;
            ovr_r   <= 8'h00;
        end
        else if (ce)
        begin
            valid_r <= res_hit | (valid_r & ~rd_clr);          // [RULE22]
            ovr_r   <= (res_hit & valid_r & ~rd_clr) |
                       (ovr_r & ~rd_clr);                      // [RULE23]
        end

    generate
        for (genvar g = 0; g < 2; g++)
        begin : g_cmp
            logic hit, match;
            assign hit   = res_we && cmp_r[g][`B_CMP_EN] &&
                           chan_r == cmp_r[g][`B_CMP_CH];      // [RULE16]
            assign match = cmp_r[g][`B_CMP_DIR] ?
                           (conv_data >= cmp_r[g][`B_CMP_VAL]) :
                           (conv_data <  cmp_r[g][`B_CMP_VAL]);
            assign cmp_set[g] = hit && match &&
                   (match_cnt_r[g] == {1'b0, cmp_r[g][`B_CMP_CNT]});
            always_ff @(posedge clk or posedge rst)
                if (rst)
                begin
                    cmp_r[g]       <= 32'h0;
                    match_cnt_r[g] <= 5'h00;
                end
                else if (ce)
                begin
                    if (wr && addr == (g == 0 ? `OFS_CMP_A : `OFS_CMP_B))
                        cmp_r[g] <= wdata & `CMP_MASK;
                    if (cmp_set[g])
                        match_cnt_r[g] <= 5'h00;               // [RULE18]
                    else if (hit && match)
                        match_cnt_r[g] <= match_cnt_r[g] + 5'h01;
                    else if (hit)
                        match_cnt_r[g] <= 5'h00;               // [RULE17]
                end
        end
    endgenerate

    // write one clears; a hardware set in the same cycle wins
    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            end_flag_r <= 1'b0;
            cmp_flag_r <= 2'h0;
            irq_r      <= 1'b0;
        end
        else if (ce)
        begin
            end_flag_r <= pass_done | (end_flag_r &                // [RULE5]
                ~(wr && addr == `OFS_STATUS && wdata[`B_ST_END])); // [RULE20]
            cmp_flag_r <= cmp_set | (cmp_flag_r &
                ~((wr && addr == `OFS_STATUS) ? wdata[`B_ST_CMP] : 2'h0));
            irq_r <= (end_flag_r && ie_r) ||
                     (cmp_flag_r[0] && cmp_r[0][`B_CMP_IE]) ||
                     (cmp_flag_r[1] && cmp_r[1][`B_CMP_IE]); // [RULE19]
        end

    always_comb
    begin
        alt_word = 32'h0;
        if (addr == `OFS_CTRL)
        begin
            alt_word[`B_EN]      = en_r;
            alt_word[`B_IE]      = ie_r;
            alt_word[`B_MODE]    = mode_r;
            alt_word[`B_TRIGGER_SOURCE_SELECT]    = trigger_source_select_r;
            alt_word[`B_TRIGGER_CONDITION_SELECT] = cond_r;
            alt_word[`B_EXT_TRIGGER_ENABLE]   = ext_trigger_enable_r;
            alt_word[`B_START]   = start_r;
            alt_word[`B_FORMAT]  = format_r;
        end
        else if (addr == `OFS_CHANNEL_ENABLE_BITS)
            alt_word[`B_CHANNEL_ENABLE_BITS] = channel_enable_bits_r;
        else if (addr == `OFS_CMP_A)
            alt_word = cmp_r[0];
        else if (addr == `OFS_CMP_B)
            alt_word = cmp_r[1];
        else if (addr == `OFS_STATUS)
        begin
            alt_word[`B_ST_END]   = end_flag_r;
            alt_word[`B_ST_CMP]   = cmp_flag_r;
            alt_word[`B_ST_BUSY]  = (state_r != st_idle);
            alt_word[`B_ST_CH]    = chan_r;
            alt_word[`B_ST_VALID] = valid_r;
            alt_word[`B_ST_OVR]   = ovr_r;
        end
        else if (addr == `OFS_CLKCFG)
        begin
            alt_word[`B_CK_SEL] = clksel_r;
            alt_word[`B_CK_DIV] = div_r;
            alt_word[`B_CK_BG]  = bg_r;
        end
    end

    result_store u_store
    (
        .clk         (clk),
        .rst         (rst),
        .ce          (ce),
        .wr_en       (res_we),
        .wr_idx      (chan_r),
        .wr_data     (res_word),
        .rd_en       (rd),
        .rd_from_mem (res_sel),
        .rd_idx      (res_idx),
        .rd_flags    ({valid_r[res_idx], ovr_r[res_idx]}),
        .alt_word    (alt_word),
        .rdata       (rdata)
    );

    assign conv_tick       = tick_r;
    assign conv_start      = conv_start_r;
    assign conv_chan       = chan_r;
    assign ch7_bandgap_sel = bg_r;
    assign irq             = irq_r;                            // [RULE26]

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_single_done;
        ce && res_we && mode_r == `MODE_SINGLE
            |=> !start_r && state_r == st_idle && end_flag_r;
    endproperty
    a_single_done: assert property (p_single_done) // [RULE1] [RULE2]
        else $error("single conversion did not end cleanly");
    property p_lowest;
        state_r == st_launch && mode_r == `MODE_SINGLE && !$past(res_we)
            |-> chan_r == first_lo[2:0];
    endproperty
    a_lowest: assert property (p_lowest) // [RULE3]
        else $error("single mode picked a wrong channel");
    property p_ascend;
        ce && res_we && mode_r == `MODE_SCAN && start_r && next_up[3]
            |=> state_r == st_launch && chan_r > $past(chan_r);
    endproperty
    a_ascend: assert property (p_ascend) // [RULE4]
        else $error("scan did not move to a higher channel");
    property p_end_flag;
        ce && pass_done |=> end_flag_r;
    endproperty
    a_end_flag: assert property (p_end_flag) // [RULE5]
        else $error("end flag missing after pass");
    property p_abort;
        ce && res_we && mode_r != `MODE_SINGLE && !start_r
            |=> state_r == st_idle && valid_r[$past(chan_r)];
    endproperty
    a_abort: assert property (p_abort) // [RULE6]
        else $error("stopped scan lost its last result");
    property p_restart;
        ce && res_we && mode_r == `MODE_CONT && start_r && !next_up[3]
            |=> state_r == st_launch && {1'b1, chan_r} == $past(first_lo)
                && start_r;
    endproperty
    a_restart: assert property (p_restart) // [RULE7]
        else $error("continuous scan did not restart at lowest");
    property p_irq_set;
        ce && end_flag_r && ie_r |=> irq_r;
    endproperty
    a_irq_set: assert property (p_irq_set) // [RULE19]
        else $error("enabled end flag raised no interrupt");
    property p_irq_drop;
        ce && !(end_flag_r && ie_r) && !(cmp_flag_r[0] &&
            cmp_r[0][`B_CMP_IE]) && !(cmp_flag_r[1] && cmp_r[1][`B_CMP_IE])
            |=> !irq_r;
    endproperty
    a_irq_drop: assert property (p_irq_drop) // [RULE20]
        else $error("interrupt stayed after flags cleared");
    property p_valid_clr;
        ce && rd_res && !(res_we && chan_r == res_idx)
            |=> !valid_r[$past(res_idx)] && !ovr_r[$past(res_idx)];
    endproperty
    a_valid_clr: assert property (p_valid_clr) // [RULE22]
        else $error("read did not clear valid and overrun");
    property p_cmp_flag;
        ce && cmp_set[0] |=> cmp_flag_r[0] && match_cnt_r[0] == 5'h00;
    endproperty
    a_cmp_flag: assert property (p_cmp_flag) // [RULE18]
        else $error("compare flag not set on count");
    c_single: cover property (ce && res_we && mode_r == `MODE_SINGLE);
    c_cont: cover property (p_restart);
    c_cmp: cover property (ce && cmp_set[1]);
endmodule // sar_adc_sequencer

/* hdl/adc_seq_defs.svh */
// register map, field positions and fixed counts of the converter sequencer
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH
`define OFS_RESULT_TOP 8'h1C
`define OFS_CTRL       8'h20
`define OFS_CHANNEL_ENABLE_BITS       8'h24
`define OFS_CMP_A      8'h28
`define OFS_CMP_B      8'h2C
`define OFS_STATUS     8'h30
`define OFS_CLKCFG     8'h34
`define B_EN           0
`define B_IE           1
`define B_MODE         3:2
`define B_TRIGGER_SOURCE_SELECT         5:4
`define B_TRIGGER_CONDITION_SELECT      7:6
`define B_EXT_TRIGGER_ENABLE        8
`define B_START        11
`define B_FORMAT       31
`define B_CHANNEL_ENABLE_BITS         7:0
`define B_CMP_EN       0
`define B_CMP_IE       1
`define B_CMP_DIR      2
`define B_CMP_CH       5:3
`define B_CMP_CNT      11:8
`define B_CMP_VAL      27:16
`define CMP_MASK       32'h0FFF0F3F
`define B_ST_END       0
`define B_ST_CMP       2:1
`define B_ST_BUSY      3
`define B_ST_CH        6:4
`define B_ST_VALID     15:8
`define B_ST_OVR       23:16
`define B_CK_SEL       1:0
`define B_CK_DIV       15:8
`define B_CK_BG        16
`define MODE_SINGLE    2'h0
`define MODE_SCAN      2'h2
`define MODE_CONT      2'h3
`define TRG_PIN        2'h0
`define TRG_PWM        2'h3
`define COND_FALL      2'h0
`define COND_RISE      2'h1
`define COND_LOW       2'h2
`define COND_HIGH      2'h3
`define EDGE_MIN_CLKS  4'h4
`define LEVEL_MIN_CLKS 4'h8
`endif

/* hdl/adc_seq_pkg.sv */
// shared types of the converter sequencer
package adc_seq_pkg;
    typedef enum logic [1:0] {st_idle, st_launch, st_wait} seq_state_type;
endpackage

/* hdl/ext_trigger_filter.sv */
// synchroniser and edge/level qualifier for the external trigger pin
`timescale 1ns/100ps
`include "adc_seq_defs.svh"
module ext_trigger_filter
#(
    parameter logic [3:0] EDGE_MIN  = `EDGE_MIN_CLKS,
    parameter logic [3:0] LEVEL_MIN = `LEVEL_MIN_CLKS
)
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       ce,
    input  wire logic       pin,
    input  wire logic [1:0] cond,
    output logic            edge_go,
    output logic            level_ok
);
    logic       s1_r, s2_r, s3_r, lvl_r, prev_ok_r;
    logic [3:0] cnt_r;
    logic       lvl_nxt, active;

    // a change counts only once the two later stages agree
    assign lvl_nxt = (s2_r == s3_r) ? s3_r : lvl_r;
    assign active  = (cond == `COND_HIGH) ? lvl_r : ~lvl_r;

    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end
        else if (ce)
        begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end

    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            lvl_r     <= 1'b0;
            cnt_r     <= 4'h0;
            prev_ok_r <= 1'b0;
            edge_go   <= 1'b0;
            level_ok  <= 1'b0;
        end
        else if (ce)
        begin
            lvl_r <= lvl_nxt;
            if (lvl_nxt != lvl_r)
            begin
                prev_ok_r <= (cnt_r >= EDGE_MIN);
                cnt_r     <= 4'h1;
            end
            else if (cnt_r != 4'hF)
                cnt_r <= cnt_r + 4'h1;
            // both phases must last the minimum or the pulse is dropped
            edge_go  <= !cond[1] && (lvl_nxt == lvl_r) && prev_ok_r &&
                        (cnt_r == EDGE_MIN - 4'h1) &&
                        (lvl_r == cond[0]);                    // [RULE14]
            level_ok <= cond[1] && active && (lvl_nxt == lvl_r) &&
                        (cnt_r >= LEVEL_MIN - 4'h1);           // [RULE12]
        end
endmodule // ext_trigger_filter

/* hdl/result_store.sv */
// per-channel result memory with the registered read word of the bus
`timescale 1ns/100ps
module result_store
#(
    parameter int DEPTH = 8,
    parameter int W     = 16,
    parameter int AW    = 3
)
(
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          ce,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_idx,
    input  wire logic [W-1:0]  wr_data,
    input  wire logic          rd_en,
    input  wire logic          rd_from_mem,
    input  wire logic [AW-1:0] rd_idx,
    input  wire logic [1:0]    rd_flags,
    input  wire logic [31:0]   alt_word,
    output logic [31:0]        rdata
);
    logic [W-1:0] mem_r [DEPTH];

    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            for (int i = 0; i < DEPTH; i++)
                mem_r[i] <= '0;
        end
        else if (ce && wr_en)
            mem_r[wr_idx] <= wr_data;

    // read data stand for one cycle only, zero otherwise
    always_ff @(posedge clk or posedge rst)
        if (rst)
            rdata <= 32'h0;
        else if (ce)
        begin
            if (rd_en && rd_from_mem)
                rdata <= {{(30-W){1'b0}}, rd_flags, mem_r[rd_idx]};
            else if (rd_en)
                rdata <= alt_word;
            else
                rdata <= 32'h0;
        end
endmodule // result_store

/* tb/analog_core_model.sv */
// behavioural analog core answering each conversion start
`timescale 1ns/100ps
module analog_core_model
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        start,
    input  wire logic [2:0]  chan,
    input  wire logic [11:0] base,
    input  wire logic [3:0]  lag,
    output logic             done,
    output logic [11:0]      data
);
    logic [4:0] cnt_r;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cnt_r <= 5'h00;
        else if (start)
            cnt_r <= {1'b0, lag} + 5'h01;
        else if (cnt_r != 5'h00)
            cnt_r <= cnt_r - 5'h01;
    end
    // lag 0 answers at once, 15 is slow
    assign done = (cnt_r == 5'h01);
    // data is junk that moves while no result is offered
    assign data = done ? base + {9'h000, chan} : ~(base + {7'h00, cnt_r});
endmodule // analog_core_model

/* tb/tb.sv */
// self-checking bench of the converter sequencer
`timescale 1ns/100ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_count++; \
    $display("unexpected %0t: got %h want %h", $time, a, e); end end
module tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        rd_q = 1'b0;
    logic [31:0] rdata;
    logic [31:0] ew;
    logic        done;
    logic [11:0] data;
    logic        start;
    logic [2:0]  chan;
    logic [2:0]  ec;
    logic        irq;
    logic        pwm = 1'b0;
    logic        pin = 1'b0;
    logic        tick;
    logic        bg;
    logic [2:0]  dv;
    int          tk = 0;
    logic [11:0] base = 12'h000;
    logic [3:0]  lag = 4'h0;
    logic [15:0] res_m[8];
    logic [7:0]  val_m = 8'h00;
    logic [7:0]  ovr_m = 8'h00;
    logic [31:0] exp_q[$];
    logic [2:0]  ch_q[$];
    int          err_count = 0;
    int          checks = 0;
    sar_adc_sequencer u_sar_adc_sequencer
    (
        .clk(clk), .rst(rst), .ce(1'b1), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .external_trigger_pin(pin),
        .pwm_trig(pwm), .clk_src_tick(4'h2), .conv_done(done),
        .conv_data(data), .conv_tick(tick), .conv_start(start),
        .conv_chan(chan), .ch7_bandgap_sel(bg), .irq(irq)
    );
    analog_core_model u_analog_core_model
    (
        .clk(clk), .rst(rst), .start(start), .chan(chan), .base(base),
        .lag(lag), .done(done), .data(data)
    );
    initial
    begin
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk)
        rd_q <= rd;
    always @(negedge clk)
    begin
        if (rd_q)
        begin
            ew = exp_q.pop_front();
            `CHK(rdata, ew)
        end
        if (start === 1'b1)
        begin
            ec = (ch_q.size() > 0) ? ch_q.pop_front() : 3'h7;
            `CHK(chan, ec)
        end
    end
    function automatic logic [15:0] fmt(input logic f, input logic [11:0] r);
        return f ? {{5{~r[11]}}, r[10:0]} : {4'h0, r};
    endfunction
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= w;
        rd    <= ~w;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdres(input int ch);
        exp_q.push_back({14'h0, val_m[ch], ovr_m[ch], res_m[ch]});
        val_m[ch] = 1'b0;
        ovr_m[ch] = 1'b0;
        bus(1'b0, 8'(ch * 4), 32'h0);
    endtask
    task automatic results();
        if (err_count == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic waitirq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 500)
        begin
            @(negedge clk);
            n++;
        end
        `CHK(irq, 1'b1)
        if (irq !== 1'b1)
            results();
        @(posedge clk);
    endtask
    initial
    begin
        void'($urandom(21858));
        for (int c = 0; c < 8; c++)
            res_m[c] = 16'h0000;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        exp_q.push_back(32'h0);
        bus(1'b0, 8'h20, 32'h0);
        rdres(2);
        bus(1'b1, 8'h24, 32'h0000002C);
        for (int i = 0; i < 4; i++)
        begin
            logic [31:0] cw;
            logic [11:0] b;
            // odd passes scan, upper two pass in two's complement
            cw = {i[1], 19'h0, 1'b1, 7'h0, i[0], 1'b0, 2'h3};
            b = 12'($urandom);
            base <= b;
            lag <= 4'($urandom);
            for (int c = 2; c < 6; c++)
                if (c != 4 && (i[0] || c == 2))
                begin
                    ch_q.push_back(3'(c));
                    ovr_m[c] = val_m[c];
                    val_m[c] = 1'b1;
                    res_m[c] = fmt(i[1], b + 12'(c));
                end
            // start bit is already clear before the mode changes
            bus(1'b1, 8'h20, cw);
            waitirq();
            exp_q.push_back(cw & ~32'h00000800);
            bus(1'b0, 8'h20, 32'h0);
            bus(1'b1, 8'h30, 32'h00000001);
            @(negedge clk);
            `CHK(irq, 1'b0)
            @(posedge clk);
            rdres(2);
            rdres(5);
        end
        rdres(3);
        rdres(3);
        bus(1'b1, 8'h24, 32'h00000080);
        bus(1'b1, 8'h28, {4'h0, base + 12'h7, 16'h013F});
        bus(1'b1, 8'h2C, {4'h0, base + 12'h7, 16'h013F});
        bus(1'b1, 8'h20, 32'h0000080D);
        waitirq();
        bus(1'b1, 8'h20, 32'h0000000D);
        repeat (40) @(posedge clk);
        bus(1'b1, 8'h30, 32'h00000007);
        @(negedge clk);
        `CHK(irq, 1'b0)
        @(posedge clk);
        val_m[7] = 1'b1;
        ovr_m[7] = 1'b1;
        res_m[7] = {4'h0, base + 12'h7};
        rdres(7);
        // external starts: one PWM event, then a rising pin edge
        bus(1'b1, 8'h20, 32'h0000013B);
        pwm <= 1'b1;
        @(posedge clk);
        pwm <= 1'b0;
        waitirq();
        bus(1'b1, 8'h30, 32'h00000007);
        bus(1'b1, 8'h20, 32'h0000014B);
        pin <= 1'b1;
        waitirq();
        dv = 3'($urandom);
        bus(1'b1, 8'h34, {15'h0, 1'b1, 5'h0, dv, 8'h01});
        repeat (20) @(posedge clk);
        repeat (8 * (dv + 1))
        begin
            @(negedge clk);
            tk += tick;
        end
        `CHK(tk, 8)
        `CHK(bg, 1'b1)
        `CHK(ch_q.size(), 0)
        results();
    end
endmodule // tb
